// >>> design/crm_top.sv
// Clock selection, reset sequencing and power-mode control with an APB slave.
// Overview of operation
// - System clock switches never glitch; output edges pause during a switch.
// - Old and new sources must run; a dead one stalls the switch forever.
// - Core clock runs except in deep sleep; bus clock stops in sleep.
// - Per-function clock selection switches at once and is not glitch-free.
// - Peripheral clock feeds all gated peripherals through two enable registers.
// - A peripheral with its clock gate off cannot be accessed.
// - After power-up the fast RC runs at its 2.5MHz setting as system clock.
// - Each crystal oscillator has its own enable bit in clock source control.
// - Power-on is the cold reset; six sources make a warm reset.
// - Boot waits 4ms before releasing the CPU reset.
// - Power-on flag is set by power-on or voltage drop until cleared.
// - Warm causes are recorded; per-block resets are maskable individually.
// - Undervoltage control clears to 0x00 on power-on; threshold from option.
// - After any reset the init state leads to run mode.
// - In sleep only the CPU stops; peripherals follow their gates.
// - Deep sleep stops CPU and system clock; watch and watchdog clocks run.
// - An enabled running peripheral interrupt wakes sleep; all but the watchdog interrupt also wake deep sleep.
// - The watchdog interrupt never wakes the device from deep sleep.
// - Watchdog RC is 40kHz and the sub crystal 32.768kHz.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module crm_top #(
   parameter int BOOT_CYC = crm_pkg::BOOT_CYC,
   parameter int MON_DOG_CYC = crm_pkg::MON_DOG_CYC,
   parameter int MON_SUB_CYC = crm_pkg::MON_SUB_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic internal_fast_rc_osc,
   input wire logic main_crystal_osc,
   input wire logic sub_crystal_osc,
   input wire logic watchdog_rc_osc,
   input wire logic external_reset_pin_n,
   input wire logic watchdog_reset_req,
   input wire logic undervoltage_reset,
   input wire logic clock_monitor_fault,
   input wire logic cpu_reset_req,
   input wire logic voltage_drop,
   input wire logic sleep_req,
   input wire logic [31:0] periph_irq,
   input wire logic [3:0] undervoltage_threshold_option,
   output logic fast_rc_enable,
   output logic main_crystal_enable,
   output logic sub_crystal_enable,
   output logic [1:0] fast_rc_freq,
   output logic free_running_core_clock_en,
   output logic bus_clk_en,
   output logic [63:0] periph_clk_en,
   output logic [63:0] periph_access_en,
   output logic misc_clk_en,
   output logic watch_clk_en,
   output logic watchdog_clk_en,
   output logic cpu_rst_n,
   output logic [31:0] periph_rst_n,
   output logic [7:0] undervoltage_reset_control,
   output logic [3:0] undervoltage_level,
   output logic [3:0] mode
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] prev;
      logic [3:0][13:0] alive_cnt;
      logic [3:0] alive;
      crm_pkg::crm_sw_t sw;
      logic edge_cnt;
      logic [1:0] src_cur;
      logic [1:0] src_req;
      logic [1:0] src_tgt;
      logic [1:0] misc_sel;
      logic fast_en;
      logic main_en;
      logic sub_en;
      logic [1:0] fast_freq;
      crm_pkg::crm_mode_t mode;
      logic [19:0] cnt;
      logic deep_sel;
      logic sw_rst;
      logic [6:0] status;
      logic [31:0] blk_rst;
      logic [31:0] rst_mask;
      logic [31:0] gate_one;
      logic [31:0] gate_two;
      logic [7:0] uv_ctrl;
      logic [3:0] uv_level;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic core_en;
      logic bus_en;
      logic [63:0] pclk_en;
      logic [63:0] access;
      logic misc_en;
      logic watch_en;
      logic dog_en;
      logic cpu_rst_n;
      logic [31:0] prst_n;
   } crm_state_t;

   crm_state_t s;
   crm_state_t n;
   logic [3:0] rise;
   logic sys_edge;
   logic [5:0] warm;
   logic wake_sleep;
   logic wake_deep;

   // Longest gap between edges before a source counts as stopped.
   function automatic logic [13:0] crm_limit(input logic [1:0] src);
      case (src)
         crm_pkg::SRC_SUB: crm_limit = 14'(MON_SUB_CYC);
         crm_pkg::SRC_DOG: crm_limit = 14'(MON_DOG_CYC);
         default: crm_limit = 14'(crm_pkg::MON_FAST_CYC);
      endcase
   endfunction : crm_limit

   assign rise = s.s2[3:0] & ~s.prev[3:0];
   assign sys_edge = rise[s.src_cur] & (s.sw == crm_pkg::SW_IDLE);
   assign warm = {cpu_reset_req, s.sw_rst, clock_monitor_fault, undervoltage_reset,
                  watchdog_reset_req, ~s.s2[4]};
   assign wake_sleep = |(periph_irq & s.gate_one);
   assign wake_deep = |(periph_irq & s.gate_one & crm_pkg::DEEP_WAKE_MASK
                        & ~(32'h0000_0001 << crm_pkg::DOG_IRQ_BIT));

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      n = s;
      n.s1 = {external_reset_pin_n, watchdog_rc_osc, sub_crystal_osc,
              main_crystal_osc, internal_fast_rc_osc};
      n.s2 = s.s1;
      n.prev = s.s2;
      for (int i = 0; i < 4; i++) begin
         if (rise[i]) begin
            n.alive_cnt[i] = 14'h0000;
            n.alive[i] = 1'b1;
         end else if (s.alive_cnt[i] >= crm_limit(2'(i))) begin
            n.alive[i] = 1'b0;
         end else begin
            n.alive_cnt[i] = s.alive_cnt[i] + 14'h0001;
         end
      end
      // Two edges of the old source close its gate, two of the new open it.
      case (s.sw)
         crm_pkg::SW_IDLE: begin
            if (s.src_req != s.src_cur) begin
               n.sw = crm_pkg::SW_OFF;
               n.src_tgt = s.src_req;
               n.edge_cnt = 1'b0;
            end
         end
         crm_pkg::SW_OFF: begin
            if (rise[s.src_cur]) begin
               n.edge_cnt = 1'b1;
               if (s.edge_cnt) begin
                  n.sw = crm_pkg::SW_ON;
                  n.edge_cnt = 1'b0;
               end
            end
         end
         crm_pkg::SW_ON: begin
            if (rise[s.src_tgt]) begin
               n.edge_cnt = 1'b1;
               if (s.edge_cnt) begin
                  n.sw = crm_pkg::SW_IDLE;
                  n.src_cur = s.src_tgt;
               end
            end
         end
         default: n.sw = crm_pkg::SW_IDLE;
      endcase
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.sw_rst = 1'b0;
      if (psel && penable && !s.pready) begin
         n.pready = 1'b1;
         n.prdata = 32'h0000_0000;
         case (paddr)
            crm_pkg::OFS_CLK_SRC: begin
               n.prdata[crm_pkg::F_SYS_SEL +: 2] = s.src_req;
               n.prdata[crm_pkg::F_FAST_EN] = s.fast_en;
               n.prdata[crm_pkg::F_MAIN_EN] = s.main_en;
               n.prdata[crm_pkg::F_SUB_EN] = s.sub_en;
               n.prdata[crm_pkg::F_FAST_FREQ +: 2] = s.fast_freq;
               n.prdata[crm_pkg::F_MISC_SEL +: 2] = s.misc_sel;
               n.prdata[crm_pkg::F_BUSY] = (s.sw != crm_pkg::SW_IDLE);
            end
            crm_pkg::OFS_CLK_MON: n.prdata[3:0] = s.alive;
            crm_pkg::OFS_RST_STAT: n.prdata[6:0] = s.status;
            crm_pkg::OFS_BLK_RST: n.prdata = s.blk_rst;
            crm_pkg::OFS_RST_MASK: n.prdata = s.rst_mask;
            crm_pkg::OFS_GATE_ONE: n.prdata = s.gate_one;
            crm_pkg::OFS_GATE_TWO: n.prdata = s.gate_two;
            crm_pkg::OFS_UV_CTRL: n.prdata[7:0] = s.uv_ctrl;
            crm_pkg::OFS_MODE: begin
               n.prdata[crm_pkg::F_DEEP_SEL] = s.deep_sel;
               n.prdata[crm_pkg::F_MODE +: 4] = s.mode;
            end
            default: n.pslverr = 1'b1;
         endcase
      end
      if (psel && penable && s.pready && pwrite && !s.pslverr) begin
         case (paddr)
            crm_pkg::OFS_CLK_SRC: begin
               n.src_req = pwdata[crm_pkg::F_SYS_SEL +: 2];
               n.fast_en = pwdata[crm_pkg::F_FAST_EN];
               n.main_en = pwdata[crm_pkg::F_MAIN_EN];
               n.sub_en = pwdata[crm_pkg::F_SUB_EN];
               n.fast_freq = pwdata[crm_pkg::F_FAST_FREQ +: 2];
               n.misc_sel = pwdata[crm_pkg::F_MISC_SEL +: 2];
            end
            crm_pkg::OFS_RST_STAT: n.status = s.status & ~pwdata[6:0];
            crm_pkg::OFS_BLK_RST: n.blk_rst = pwdata;
            crm_pkg::OFS_RST_MASK: n.rst_mask = pwdata;
            crm_pkg::OFS_GATE_ONE: n.gate_one = pwdata;
            crm_pkg::OFS_GATE_TWO: n.gate_two = pwdata;
            crm_pkg::OFS_UV_CTRL: n.uv_ctrl = pwdata[7:0];
            crm_pkg::OFS_MODE: begin
               n.deep_sel = pwdata[crm_pkg::F_DEEP_SEL];
               n.sw_rst = pwdata[crm_pkg::F_SW_RST];
            end
            default: n.pslverr = 1'b0;
         endcase
      end
      // Hardware sets come after the software clear so that they win.
      n.status[6:1] = n.status[6:1] | warm;
      if (voltage_drop) begin
         n.status[0] = 1'b1;
      end
      case (s.mode)
         crm_pkg::M_INIT: begin
            n.uv_level = undervoltage_threshold_option;
            if (s.cnt == 20'h0_0000) begin
               n.mode = crm_pkg::M_RUN;
            end else begin
               n.cnt = s.cnt - 20'h0_0001;
            end
         end
         crm_pkg::M_RUN: begin
            if (sleep_req) begin
               n.mode = s.deep_sel ? crm_pkg::M_DEEP : crm_pkg::M_SLEEP;
            end
         end
         crm_pkg::M_SLEEP: begin
            if (wake_sleep) begin
               n.mode = crm_pkg::M_RUN;
            end
         end
         crm_pkg::M_DEEP: begin
            if (wake_deep) begin
               n.mode = crm_pkg::M_RUN;
            end
         end
         default: n.mode = crm_pkg::M_INIT;
      endcase
      if ((|warm) || voltage_drop) begin
         n.mode = crm_pkg::M_INIT;
         n.cnt = 20'(crm_pkg::WARM_RST_CYC - 1);
      end
      n.core_en = sys_edge && (s.mode != crm_pkg::M_DEEP);
      n.bus_en = sys_edge && (s.mode == crm_pkg::M_RUN);
      n.pclk_en = {s.gate_two, s.gate_one} & {64{n.core_en}};
      n.access = {s.gate_two, s.gate_one};
      n.misc_en = rise[s.misc_sel];
      n.watch_en = rise[crm_pkg::SRC_SUB];
      n.dog_en = rise[crm_pkg::SRC_DOG];
      n.cpu_rst_n = (n.mode != crm_pkg::M_INIT);
      n.prst_n = ~(s.blk_rst | ({32{(|warm) || voltage_drop}} & ~s.rst_mask));
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.s1 <= crm_pkg::SYNC_RST;
         s.s2 <= crm_pkg::SYNC_RST;
         s.prev <= crm_pkg::SYNC_RST;
         s.sw <= crm_pkg::SW_IDLE;
         s.src_cur <= crm_pkg::SRC_FAST;
         s.src_req <= crm_pkg::SRC_FAST;
         s.src_tgt <= crm_pkg::SRC_FAST;
         s.fast_en <= 1'b1;
         s.fast_freq <= crm_pkg::FAST_FREQ_RST;
         s.mode <= crm_pkg::M_INIT;
         s.cnt <= 20'(BOOT_CYC - 1);
         s.status <= crm_pkg::STAT_RST;
         s.uv_ctrl <= crm_pkg::UV_CTRL_RST;
         s.prst_n <= 32'h0000_0000;
      end else begin
         s <= n;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign fast_rc_enable = s.fast_en;
   assign main_crystal_enable = s.main_en;
   assign sub_crystal_enable = s.sub_en;
   assign fast_rc_freq = s.fast_freq;
   assign free_running_core_clock_en = s.core_en;
   assign bus_clk_en = s.bus_en;
   assign periph_clk_en = s.pclk_en;
   assign periph_access_en = s.access;
   assign misc_clk_en = s.misc_en;
   assign watch_clk_en = s.watch_en;
   assign watchdog_clk_en = s.dog_en;
   assign cpu_rst_n = s.cpu_rst_n;
   assign periph_rst_n = s.prst_n;
   assign undervoltage_reset_control = s.uv_ctrl;
   assign undervoltage_level = s.uv_level;
   assign mode = s.mode;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence seq_sleeping;
      s.mode == crm_pkg::M_SLEEP && wake_sleep && !(|warm) && !voltage_drop;
   endsequence
   sequence seq_deep_dog_only;
      s.mode == crm_pkg::M_DEEP && !wake_deep && !(|warm) && !voltage_drop;
   endsequence

   a_switch_quiet: assert property (@(posedge clk) disable iff (!rstn)
      s.sw != crm_pkg::SW_IDLE |=> !free_running_core_clock_en)
      else $error("core clock edge during a source switch");
   a_switch_dead: assert property (@(posedge clk) disable iff (!rstn)
      (s.sw == crm_pkg::SW_ON && !rise[s.src_tgt]) |=> s.sw == crm_pkg::SW_ON)
      else $error("switch finished without new source edges");
   a_bus_sleep: assert property (@(posedge clk) disable iff (!rstn)
      s.mode == crm_pkg::M_SLEEP |=> !bus_clk_en)
      else $error("bus clock ran in sleep");
   a_deep_core: assert property (@(posedge clk) disable iff (!rstn)
      s.mode == crm_pkg::M_DEEP |=> !free_running_core_clock_en && periph_clk_en == 64'h0)
      else $error("system clock ran in deep sleep");
   a_gate_access: assert property (@(posedge clk) disable iff (!rstn)
      ##1 (periph_access_en & ~$past({s.gate_two, s.gate_one})) == 64'h0)
      else $error("ungated peripheral accessible");
   a_por_flag: assert property (@(posedge clk) disable iff (!rstn)
      voltage_drop |=> s.status[0] && !cpu_rst_n)
      else $error("voltage drop not recorded");
   a_warm_cause: assert property (@(posedge clk) disable iff (!rstn)
      watchdog_reset_req |=> s.status[2] ##1 !cpu_rst_n)
      else $error("watchdog reset not recorded");
   a_warm_release: assert property (@(posedge clk) disable iff (!rstn)
      (s.mode == crm_pkg::M_INIT && s.cnt == 20'h0_0002 && !(|warm) && !voltage_drop)
      ##1 (!(|warm) && !voltage_drop) |=> !cpu_rst_n ##1 cpu_rst_n)
      else $error("cpu reset release off by one");
   a_sleep_wake: assert property (@(posedge clk) disable iff (!rstn)
      seq_sleeping |=> s.mode == crm_pkg::M_RUN)
      else $error("no wake from sleep");
   a_dog_no_wake: assert property (@(posedge clk) disable iff (!rstn)
      seq_deep_dog_only |=> s.mode == crm_pkg::M_DEEP)
      else $error("woke from deep sleep without a wake source");
   a_misc_follow: assert property (@(posedge clk) disable iff (!rstn)
      rise[s.misc_sel] |=> misc_clk_en)
      else $error("function clock missed a source edge");
endmodule : crm_top
`default_nettype wire

// >>> design/crm_pkg.sv
// Constants and types shared by the clock, reset and mode controller.
package crm_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 250_000_000;
   localparam int BOOT_TIME_MS = 4;
   localparam int BOOT_CYC = BOOT_TIME_MS * (CLK_HZ / 1000);
   localparam int WARM_RST_CYC = 16;
   localparam int MAIN_MIN_HZ = 2_000_000;
   localparam int DOG_RC_HZ = 40_000;
   localparam int SUB_XTAL_HZ = 32_768;
   // A source is dead when two of its slowest periods pass without an edge.
   localparam int MON_FAST_CYC = 2 * ((CLK_HZ + MAIN_MIN_HZ - 1) / MAIN_MIN_HZ);
   localparam int MON_DOG_CYC = 2 * ((CLK_HZ + DOG_RC_HZ - 1) / DOG_RC_HZ);
   localparam int MON_SUB_CYC = 2 * ((CLK_HZ + SUB_XTAL_HZ - 1) / SUB_XTAL_HZ);
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CLK_SRC = 8'h00;
   localparam logic [7:0] OFS_CLK_MON = 8'h04;
   localparam logic [7:0] OFS_RST_STAT = 8'h08;
   localparam logic [7:0] OFS_BLK_RST = 8'h0C;
   localparam logic [7:0] OFS_RST_MASK = 8'h10;
   localparam logic [7:0] OFS_GATE_ONE = 8'h14;
   localparam logic [7:0] OFS_GATE_TWO = 8'h18;
   localparam logic [7:0] OFS_UV_CTRL = 8'h1C;
   localparam logic [7:0] OFS_MODE = 8'h20;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int F_SYS_SEL = 0;
   localparam int F_FAST_EN = 4;
   localparam int F_MAIN_EN = 5;
   localparam int F_SUB_EN = 6;
   localparam int F_FAST_FREQ = 8;
   localparam int F_MISC_SEL = 12;
   localparam int F_BUSY = 16;
   localparam int F_DEEP_SEL = 0;
   localparam int F_SW_RST = 1;
   localparam int F_MODE = 4;
   localparam logic [1:0] SRC_FAST = 2'h0;
   localparam logic [1:0] SRC_MAIN = 2'h1;
   localparam logic [1:0] SRC_SUB = 2'h2;
   localparam logic [1:0] SRC_DOG = 2'h3;
   localparam logic [1:0] FAST_FREQ_RST = 2'h0;
   localparam logic [7:0] UV_CTRL_RST = 8'h00;
   localparam logic [6:0] STAT_RST = 7'h01;
   localparam logic [4:0] SYNC_RST = 5'h10;
   localparam int DOG_IRQ_BIT = 2;
   localparam logic [31:0] DEEP_WAKE_MASK = 32'hFFFF_FFFF;
   // ---------------------------------------------------------------
   // State encodings
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      M_INIT = 4'h1,
      M_RUN = 4'h2,
      M_SLEEP = 4'h4,
      M_DEEP = 4'h8
   } crm_mode_t;
   typedef enum logic [2:0] {
      SW_IDLE = 3'h1,
      SW_OFF = 3'h2,
      SW_ON = 3'h4
   } crm_sw_t;
endpackage : crm_pkg

// >>> testbench/crm_osc_model.sv
// Behavioural model of the four oscillators that feed the controller.
`timescale 1ns/100ps
`default_nettype none
module crm_osc_model (
   input wire logic clk,
   input wire logic fast_en,
   input wire logic main_en,
   input wire logic sub_en,
   output logic fast_osc,
   output logic main_osc,
   output logic sub_osc,
   output logic dog_osc
);
   // ---------------------------------------------------------------
   // Oscillators
   // ---------------------------------------------------------------
   logic [3:0] cnt = 4'h0;
   always @(posedge clk) begin
      cnt <= cnt + 4'h1;
   end
   assign fast_osc = fast_en & cnt[0];
   assign main_osc = main_en & cnt[1];
   assign sub_osc = sub_en & cnt[3];
   assign dog_osc = cnt[2];
endmodule : crm_osc_model
`default_nettype wire

// >>> testbench/clock_reset_mode_control_tb.sv
// Self-checking bench for the clock, reset and mode controller.
`timescale 1ns/100ps
`default_nettype none
module clock_reset_mode_control_tb;
   localparam int BOOT = 20;
   typedef struct {logic [31:0] e; logic [31:0] m; logic r;} crm_note_t;
   crm_note_t notes[$];
   crm_note_t nt;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, g1, g2;
   logic internal_fast_rc_osc, main_crystal_osc, sub_crystal_osc, watchdog_rc_osc;
   logic external_reset_pin_n, watchdog_reset_req, undervoltage_reset;
   logic clock_monitor_fault, cpu_reset_req, voltage_drop, sleep_req;
   logic [31:0] periph_irq, periph_rst_n;
   logic [3:0] undervoltage_threshold_option, undervoltage_level, mode;
   logic fast_rc_enable, main_crystal_enable, sub_crystal_enable, bus_clk_en;
   logic free_running_core_clock_en, misc_clk_en, watch_clk_en, watchdog_clk_en, cpu_rst_n;
   logic [1:0] fast_rc_freq;
   logic [63:0] periph_clk_en, periph_access_en, gate_exp;
   logic [7:0] undervoltage_reset_control;
   int fail_count, total_checks, core_cnt, bus_cnt, watch_cnt, bad_gate, i, n;
   crm_top #(.BOOT_CYC(BOOT), .MON_DOG_CYC(40), .MON_SUB_CYC(40)) dut (
      .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .internal_fast_rc_osc, .main_crystal_osc, .sub_crystal_osc, .watchdog_rc_osc,
      .external_reset_pin_n, .watchdog_reset_req, .undervoltage_reset, .clock_monitor_fault,
      .cpu_reset_req, .voltage_drop, .sleep_req, .periph_irq, .undervoltage_threshold_option,
      .fast_rc_enable, .main_crystal_enable, .sub_crystal_enable, .fast_rc_freq,
      .free_running_core_clock_en, .bus_clk_en, .periph_clk_en, .periph_access_en,
      .misc_clk_en, .watch_clk_en, .watchdog_clk_en, .cpu_rst_n, .periph_rst_n,
      .undervoltage_reset_control, .undervoltage_level, .mode);
   crm_osc_model osc (.clk, .fast_en(fast_rc_enable), .main_en(main_crystal_enable),
      .sub_en(sub_crystal_enable), .fast_osc(internal_fast_rc_osc),
      .main_osc(main_crystal_osc), .sub_osc(sub_crystal_osc), .dog_osc(watchdog_rc_osc));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] m, input logic [31:0] e, input logic er);
      int k;
      k = 0;
      notes.push_back('{e, m, er});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         stop_test();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, 32'hFFFF_FFFF, e, 1'b0);
   endtask : rdc
   task automatic pulse_sleep();
      @(posedge clk);
      sleep_req <= 1'b1;
      @(posedge clk);
      sleep_req <= 1'b0;
      repeat (2) @(negedge clk);
   endtask : pulse_sleep
   task automatic wake(input logic [31:0] v);
      @(posedge clk);
      periph_irq <= v;
      @(posedge clk);
      periph_irq <= '0;
      @(negedge clk);
   endtask : wake
   task automatic warm(input int src, input logic [31:0] e, input logic [31:0] m);
      int k;
      logic low0, low1, lowc;
      k = 0;
      low0 = 1'b0;
      low1 = 1'b0;
      lowc = 1'b0;
      if (src == 6) wr(crm_pkg::OFS_MODE, 32'h0000_0002);
      else @(posedge clk);
      case (src)
         0: external_reset_pin_n <= 1'b0;
         1: watchdog_reset_req <= 1'b1;
         2: undervoltage_reset <= 1'b1;
         3: clock_monitor_fault <= 1'b1;
         4: cpu_reset_req <= 1'b1;
         5: voltage_drop <= 1'b1;
         default: k = 0;
      endcase
      @(posedge clk);
      {watchdog_reset_req, undervoltage_reset, clock_monitor_fault} <= 3'h0;
      {cpu_reset_req, voltage_drop, external_reset_pin_n} <= 3'h1;
      do begin
         @(negedge clk);
         k++;
         lowc |= (cpu_rst_n === 1'b0);
         low0 |= (periph_rst_n[0] === 1'b0);
         low1 |= (periph_rst_n[1] === 1'b0);
      end while (!(lowc && mode === 4'h2) && k < 300);
      check("warm_run", 1, lowc && mode === 4'h2);
      check("blk0_low", 1, low0);
      check("blk1_masked", 0, low1);
      apb(1'b0, crm_pkg::OFS_RST_STAT, 32'h0000_0000, m, e, 1'b0);
      wr(crm_pkg::OFS_RST_STAT, 32'h0000_007F);
   endtask : warm
   // ---------------------------------------------------------------
   // Monitors
   // ---------------------------------------------------------------
   always @(negedge clk) begin
      core_cnt += free_running_core_clock_en;
      bus_cnt += bus_clk_en;
      watch_cnt += watch_clk_en;
      bad_gate += |(periph_clk_en & ~gate_exp);
      if (pready === 1'b1) begin
         if (notes.size() == 0) check("note", 1, 0);
         else begin
            nt = notes.pop_front();
            check("prdata", nt.e, prdata & nt.m);
            check("pslverr", nt.r, pslverr);
         end
      end
   end
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #400000;
      fail_count++;
      stop_test();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata, sleep_req, periph_irq, gate_exp} = '0;
      {watchdog_reset_req, undervoltage_reset, clock_monitor_fault} = 3'h0;
      {cpu_reset_req, voltage_drop, external_reset_pin_n} = 3'h1;
      seed = 32'ha4688894;
      undervoltage_threshold_option = 4'(xs());
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (BOOT - 1) @(posedge clk);
      @(negedge clk);
      check("cpu_rst_boot", 0, cpu_rst_n);
      @(negedge clk);
      check("cpu_rst_run", 1, cpu_rst_n);
      check("src_en", 3'h4, {fast_rc_enable, main_crystal_enable, sub_crystal_enable});
      check("fast_freq", 0, fast_rc_freq);
      check("uv_level", undervoltage_threshold_option, undervoltage_level);
      rdc(crm_pkg::OFS_CLK_SRC, 32'h0000_0010);
      rdc(crm_pkg::OFS_RST_STAT, 32'h0000_0001);
      rdc(crm_pkg::OFS_UV_CTRL, 32'h0000_0000);
      rdc(crm_pkg::OFS_MODE, 32'h0000_0020);
      apb(1'b0, 8'h40, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
      wr(crm_pkg::OFS_UV_CTRL, 32'h0000_00A5);
      rdc(crm_pkg::OFS_UV_CTRL, 32'h0000_00A5);
      check("uv_ctrl", 8'hA5, undervoltage_reset_control);
      wr(crm_pkg::OFS_CLK_SRC, 32'h0000_0070);
      @(negedge clk);
      check("xtal_en", 2'h3, {main_crystal_enable, sub_crystal_enable});
      repeat (60) @(posedge clk);
      apb(1'b0, crm_pkg::OFS_CLK_MON, 32'h0, 32'h0000_000F, 32'h0000_000F, 1'b0);
      for (i = 1; i < 5; i++) begin
         wr(crm_pkg::OFS_CLK_SRC, 32'h0000_1070 | (i % 4));
         n = 0;
         do begin
            apb(1'b0, crm_pkg::OFS_CLK_SRC, 32'h0, 32'h0, 32'h0, 1'b0);
            n++;
         end while (rd[16] !== 1'b0 && n < 50);
         rdc(crm_pkg::OFS_CLK_SRC, 32'h0000_1070 | (i % 4));
         core_cnt = 0;
         repeat (40) @(negedge clk);
         check("core_pulses", 1, core_cnt != 0);
      end
      g1 = xs() | 32'h0000_0024;
      g2 = xs();
      gate_exp = {g2, g1};
      wr(crm_pkg::OFS_GATE_ONE, g1);
      wr(crm_pkg::OFS_GATE_TWO, g2);
      rdc(crm_pkg::OFS_GATE_ONE, g1);
      rdc(crm_pkg::OFS_GATE_TWO, g2);
      repeat (2) @(negedge clk);
      check("access_en", {g2, g1}, periph_access_en);
      wr(crm_pkg::OFS_BLK_RST, 32'h0000_0001);
      repeat (2) @(negedge clk);
      check("blk_rst", 0, periph_rst_n[0]);
      wr(crm_pkg::OFS_BLK_RST, 32'h0000_0000);
      wr(crm_pkg::OFS_RST_MASK, 32'h0000_0002);
      pulse_sleep();
      check("sleep", 4'h4, mode);
      {core_cnt, bus_cnt} = '0;
      repeat (30) @(negedge clk);
      check("bus_sleep", 0, bus_cnt);
      check("core_sleep", 1, core_cnt != 0);
      wake(32'h0000_0020);
      check("wake_sleep", 4'h2, mode);
      wr(crm_pkg::OFS_MODE, 32'h0000_0001);
      pulse_sleep();
      check("deep", 4'h8, mode);
      {core_cnt, watch_cnt} = '0;
      @(posedge clk);
      periph_irq <= 32'h0000_0004;
      repeat (30) @(negedge clk);
      check("dog_no_wake", 4'h8, mode);
      check("core_deep", 0, core_cnt);
      check("watch_deep", 1, watch_cnt != 0);
      wake(32'h0000_0024);
      check("wake_deep", 4'h2, mode);
      wr(crm_pkg::OFS_MODE, 32'h0000_0000);
      check("gate_leak", 0, bad_gate);
      wr(crm_pkg::OFS_RST_STAT, 32'h0000_007F);
      rdc(crm_pkg::OFS_RST_STAT, 32'h0000_0000);
      for (i = 0; i < 7; i++) begin
         rd = (i == 5) ? 32'h1 : (i == 6) ? 32'h20 : (i == 4) ? 32'h40 : (32'h2 << i);
         warm(i, rd, (i == 5) ? 32'h1 : 32'h7F);
      end
      stop_test();
   end
endmodule : clock_reset_mode_control_tb
`default_nettype wire
